// ==== verilog/ect_timer.sv ====
// Execution-clock timer that holds instruction issue for each instruction's cycle count
module ect_timer
   import ect_pkg::*;
(
   input wire logic CLK_SYS_IN,
   input wire logic RSTN_IN,
   input wire logic [2:0] VARIANT_IN,
   input wire logic ISSUE_VALID_IN,
   input wire logic [4:0] CLASS_IN,
   input wire logic COND_TRUE_IN,
   input wire logic PSW_WRITE_IN,
   input wire logic [WAIT_W-1:0] READ_WAITS_IN,
   input wire logic [LIST_W-1:0] FRAME_N_IN,
   input wire logic [REG_W-1:0] LOW_RESULT_DESTINATION_IN,
   input wire logic [REG_W-1:0] HIGH_RESULT_DESTINATION_IN,
   input wire logic [CNT_W-1:0] MUL_BASE_CLOCKS_IN,
   output logic ISSUE_READY_OUT,
   output logic ILLEGAL_OP_OUT,
   output logic [CNT_W-1:0] LAST_CLOCKS_OUT
);

   ////////////////////////////////////////////////////////////////////////////
   // Cycle count of the offered instruction

   ect_variant_t variant;
   ect_class_t cls;
   logic [CNT_W-1:0] clocks;
   logic [CNT_W-1:0] frame_n;
   logic [CNT_W-1:0] ctl_add_d;
   logic [CNT_W-1:0] ctl_add_e;
   logic illegal;
   logic psw_prev_reg;
   logic psw_prev_next;
   // Per-group cycle counts, merged by class below
   logic late_variant;
   logic debug_absent;
   logic [CNT_W-1:0] ctl_add;
   logic [CNT_W-1:0] bcond_clocks;
   logic [CNT_W-1:0] jump_clocks;
   logic [CNT_W-1:0] special_clocks;
   logic [CNT_W-1:0] debug_clocks;
   logic [CNT_W-1:0] bit_clocks;
   logic [CNT_W-1:0] frame_ovh;
   logic [CNT_W-1:0] frame_clocks;
   logic [CNT_W-1:0] mul_clocks;
   logic mul_low_skip;
   logic mul_high_skip;

   assign variant = ect_variant_t'(VARIANT_IN);
   assign cls = ect_class_t'(CLASS_IN);

   ////////////////////////////////////////////////////////////////////////////
   // Variant adjustments

   always_comb begin
      ctl_add_d = '0;
      ctl_add_e = '0;
      late_variant = 1'b0;
      debug_absent = 1'b0;
      case (variant)
         VAR_A, VAR_B: begin
            late_variant = 1'b0;
         end
         VAR_C: begin
            // Debug function instructions are absent from this variant
            debug_absent = 1'b1;
         end
         VAR_D: begin
            ctl_add_d = CLK_ADD_VAR_D;
            late_variant = 1'b1;
         end
         VAR_E: begin
            ctl_add_e = CLK_ADD_VAR_E;
            late_variant = 1'b1;
         end
         VAR_F: begin
            late_variant = 1'b1;
         end
         default: begin
            // Unassigned codes are timed as the base variants
            late_variant = 1'b0;
         end
      endcase
      // Both adders reach every control transfer except the conditional branch, jumps and special returns alike
      ctl_add = ctl_add_d + ctl_add_e;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conditional branch

   always_comb begin
      if (!COND_TRUE_IN) begin
         bcond_clocks = CLK_ONE;
      end else if (!psw_prev_reg) begin
         bcond_clocks = CLK_BCOND_TAKEN;
      end else if (late_variant) begin
         bcond_clocks = CLK_BCOND_PSW_LATE;
      end else begin
         bcond_clocks = CLK_BCOND_PSW_EARLY;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Jumps, table calls, returns and traps

   always_comb begin
      if (cls == CLS_REGISTER_INDIRECT_JUMP) begin
         jump_clocks = CLK_JUMP_INDIRECT + ctl_add;
      end else begin
         jump_clocks = CLK_JUMP_SHORT + ctl_add;
      end
      if (cls == CLS_TABLE_CALL) begin
         special_clocks = CLK_TABLE_CALL + ctl_add;
      end else begin
         special_clocks = CLK_RETURN_TRAP + ctl_add;
      end
      // A missing debug op costs what an undefined code costs, with no variant adder
      if (debug_absent) begin
         debug_clocks = CLK_UNDEFINED;
      end else begin
         debug_clocks = CLK_RETURN_TRAP + ctl_add;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Single-bit memory operations

   always_comb begin
      // Every read wait state of the memory side stretches the operation
      bit_clocks = CLK_BIT_OP + CNT_W'(READ_WAITS_IN);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame setup and release

   always_comb begin
      // A list that loads nothing still costs one load slot
      frame_n = (FRAME_N_IN == '0) ? FRAME_N_MIN : CNT_W'(FRAME_N_IN);
      case (cls)
         CLS_FRAME_SETUP_2: begin
            frame_ovh = CLK_FRAME_OVH_2;
         end
         CLS_FRAME_RELEASE_3, CLS_FRAME_SETUP_3: begin
            frame_ovh = CLK_FRAME_OVH_3;
         end
         default: begin
            frame_ovh = CLK_FRAME_OVH_1;
         end
      endcase
      frame_clocks = frame_n + frame_ovh;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Multiply

   always_comb begin
      mul_low_skip = (LOW_RESULT_DESTINATION_IN == HIGH_RESULT_DESTINATION_IN);
      mul_high_skip = (HIGH_RESULT_DESTINATION_IN == ZERO_REGISTER);
      mul_clocks = MUL_BASE_CLOCKS_IN;
      // The floor of one clock keeps a short base count from wrapping
      if (mul_low_skip && mul_clocks > CLK_ONE) begin
         mul_clocks = mul_clocks - CLK_ONE;
      end
      if (mul_high_skip && mul_clocks > CLK_ONE) begin
         mul_clocks = mul_clocks - CLK_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Class selection

   always_comb begin
      illegal = 1'b0;
      clocks = CLK_ONE;
      case (cls)
         CLS_BCOND: begin
            clocks = bcond_clocks;
         end
         CLS_JUMP_AND_LINK, CLS_RELATIVE_JUMP, CLS_REGISTER_INDIRECT_JUMP: begin
            clocks = jump_clocks;
         end
         CLS_TABLE_CALL, CLS_TABLE_CALL_RETURN, CLS_INTERRUPT_RETURN, CLS_SOFTWARE_TRAP: begin
            clocks = special_clocks;
         end
         CLS_DEBUG_RETURN, CLS_DEBUG_TRAP_OP: begin
            illegal = debug_absent;
            clocks = debug_clocks;
         end
         CLS_BIT_OP: begin
            clocks = bit_clocks;
         end
         CLS_FRAME_RELEASE_1, CLS_FRAME_RELEASE_3, CLS_FRAME_SETUP_1, CLS_FRAME_SETUP_2,
               CLS_FRAME_SETUP_3: begin
            clocks = frame_clocks;
         end
         CLS_MULTIPLY: begin
            clocks = mul_clocks;
         end
         default: begin
            // Every other instruction issues every clock
            clocks = CLK_ONE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Issue hold counter

   ect_state_t state_reg;
   ect_state_t state_next;
   logic [CNT_W-1:0] remain_reg;
   logic [CNT_W-1:0] remain_next;
   logic [CNT_W-1:0] last_reg;
   logic [CNT_W-1:0] last_next;
   logic illegal_reg;
   logic illegal_next;
   logic accept;

   // Ready only in idle: the last busy clock still belongs to the current instruction,
   // so an instruction of C clocks is followed by the next one exactly C edges later
   assign ISSUE_READY_OUT = (state_reg == ST_IDLE);
   assign accept = ISSUE_VALID_IN && ISSUE_READY_OUT;

   always_comb begin
      state_next = state_reg;
      remain_next = remain_reg;
      unique case (state_reg)
         ST_IDLE: begin
            remain_next = '0;
         end
         ST_BUSY: begin
            remain_next = remain_reg - CLK_ONE;
            if (remain_reg == CLK_ONE) begin
               state_next = ST_IDLE;
            end
         end
      endcase
      if (accept) begin
         // A one-clock instruction leaves the counter idle so issue goes on every edge
         if (clocks > CLK_ONE) begin
            state_next = ST_BUSY;
            remain_next = clocks - CLK_ONE;
         end else begin
            state_next = ST_IDLE;
            remain_next = '0;
         end
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         state_reg <= ST_IDLE;
         remain_reg <= '0;
      end else begin
         state_reg <= state_next;
         remain_reg <= remain_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Record of the last accepted instruction

   always_comb begin
      last_next = last_reg;
      illegal_next = illegal_reg;
      psw_prev_next = psw_prev_reg;
      if (accept) begin
         // The status-word flag follows the last accepted instruction only
         psw_prev_next = PSW_WRITE_IN;
         last_next = clocks;
         illegal_next = illegal;
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         last_reg <= '0;
         illegal_reg <= 1'b0;
         psw_prev_reg <= 1'b0;
      end else begin
         last_reg <= last_next;
         illegal_reg <= illegal_next;
         psw_prev_reg <= psw_prev_next;
      end
   end

   assign LAST_CLOCKS_OUT = last_reg;
   assign ILLEGAL_OP_OUT = illegal_reg;

endmodule // ect_timer

// ==== common/ect_pkg.sv ====
// Constants, opcode classes and variant codes for the execution cycle timer
package ect_pkg;

   localparam int CNT_W = 8;
   localparam int WAIT_W = 4;
   localparam int LIST_W = 4;
   localparam int REG_W = 5;

   // Instruction classes seen by the timer
   typedef enum logic [4:0] {
      CLS_SINGLE = 5'h00,
      CLS_BCOND = 5'h01,
      CLS_JUMP_AND_LINK = 5'h02,
      CLS_RELATIVE_JUMP = 5'h03,
      CLS_REGISTER_INDIRECT_JUMP = 5'h04,
      CLS_BIT_OP = 5'h05,
      CLS_TABLE_CALL = 5'h06,
      CLS_TABLE_CALL_RETURN = 5'h07,
      CLS_INTERRUPT_RETURN = 5'h08,
      CLS_SOFTWARE_TRAP = 5'h09,
      CLS_DEBUG_RETURN = 5'h0a,
      CLS_DEBUG_TRAP_OP = 5'h0b,
      CLS_FRAME_RELEASE_1 = 5'h0c,
      CLS_FRAME_RELEASE_3 = 5'h0d,
      CLS_FRAME_SETUP_1 = 5'h0e,
      CLS_FRAME_SETUP_2 = 5'h0f,
      CLS_FRAME_SETUP_3 = 5'h10,
      CLS_MULTIPLY = 5'h11
   } ect_class_t;

   // Product variants
   typedef enum logic [2:0] {
      VAR_A = 3'h0,
      VAR_B = 3'h1,
      VAR_C = 3'h2,
      VAR_D = 3'h3,
      VAR_E = 3'h4,
      VAR_F = 3'h5
   } ect_variant_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } ect_state_t;

   localparam logic [CNT_W-1:0] CLK_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CLK_BCOND_TAKEN = 8'h02;
   localparam logic [CNT_W-1:0] CLK_BCOND_PSW_LATE = 8'h04;
   localparam logic [CNT_W-1:0] CLK_BCOND_PSW_EARLY = 8'h03;
   localparam logic [CNT_W-1:0] CLK_JUMP_SHORT = 8'h02;
   localparam logic [CNT_W-1:0] CLK_JUMP_INDIRECT = 8'h03;
   localparam logic [CNT_W-1:0] CLK_TABLE_CALL = 8'h04;
   localparam logic [CNT_W-1:0] CLK_RETURN_TRAP = 8'h03;
   localparam logic [CNT_W-1:0] CLK_ADD_VAR_D = 8'h01;
   localparam logic [CNT_W-1:0] CLK_ADD_VAR_E = 8'h02;
   localparam logic [CNT_W-1:0] CLK_BIT_OP = 8'h03;
   localparam logic [CNT_W-1:0] CLK_FRAME_OVH_1 = 8'h01;
   localparam logic [CNT_W-1:0] CLK_FRAME_OVH_2 = 8'h02;
   localparam logic [CNT_W-1:0] CLK_FRAME_OVH_3 = 8'h03;
   localparam logic [CNT_W-1:0] CLK_UNDEFINED = 8'h03;
   localparam logic [CNT_W-1:0] FRAME_N_MIN = 8'h01;
   localparam logic [REG_W-1:0] ZERO_REGISTER = 5'h00;

endpackage : ect_pkg

// ==== verification/ect_mem_model.sv ====
// Memory-side model presenting read wait states to the timer
module ect_mem_model (
   input wire logic [3:0] ws_in,
   output logic [3:0] waits_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // No clock delay, so the count qualifies the very edge that takes the bit operation
   assign waits_out = ws_in;
endmodule // ect_mem_model

// ==== verification/ect_timer_monitor.sv ====
// Concurrent checks on the execution cycle timer ports
module ect_timer_monitor
   import ect_pkg::*;
(
   input wire logic CLK_SYS_IN, RSTN_IN, ISSUE_VALID_IN, COND_TRUE_IN,
   input wire logic [2:0] VARIANT_IN,
   input wire logic [4:0] CLASS_IN, LOW_RESULT_DESTINATION_IN, HIGH_RESULT_DESTINATION_IN,
   input wire logic [3:0] READ_WAITS_IN, FRAME_N_IN,
   input wire logic [7:0] MUL_BASE_CLOCKS_IN, LAST_CLOCKS_OUT,
   input wire logic ISSUE_READY_OUT, ILLEGAL_OP_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RSTN_IN);
   wire logic tk = ISSUE_VALID_IN && ISSUE_READY_OUT;
   ////////////////////////////////////////////////////////////////////////////////
   a_ready_follow: assert property (tk |=> ISSUE_READY_OUT == (LAST_CLOCKS_OUT == 8'h01))
      else $error("ready after take disagrees with count");
   a_bcond_miss: assert property (tk && CLASS_IN == CLS_BCOND && !COND_TRUE_IN
      |=> LAST_CLOCKS_OUT == 8'h01) else $error("untaken branch not one clock");
   a_bit_wait: assert property (tk && CLASS_IN == CLS_BIT_OP
      |=> LAST_CLOCKS_OUT == 8'h03 + $past(READ_WAITS_IN)) else $error("bit op count wrong");
   a_frame_empty: assert property (tk && CLASS_IN == CLS_FRAME_SETUP_3 && FRAME_N_IN == 4'h0
      |=> LAST_CLOCKS_OUT == 8'h04) else $error("empty list not timed as one");
   a_frame_len: assert property (tk && CLASS_IN == CLS_FRAME_RELEASE_1 && FRAME_N_IN != 4'h0
      |=> LAST_CLOCKS_OUT == $past(FRAME_N_IN) + 8'h01) else $error("frame count wrong");
   a_debug_c: assert property (tk && VARIANT_IN == VAR_C &&
      CLASS_IN inside {CLS_DEBUG_RETURN, CLS_DEBUG_TRAP_OP} |=> ILLEGAL_OP_OUT)
      else $error("debug op on variant C not flagged");
   a_table_e: assert property (tk && CLASS_IN == CLS_TABLE_CALL && VARIANT_IN == VAR_E
      |=> LAST_CLOCKS_OUT == 8'h06) else $error("table call on E not six");
   a_jump_d: assert property (tk && CLASS_IN == CLS_REGISTER_INDIRECT_JUMP && VARIANT_IN == VAR_D
      |=> LAST_CLOCKS_OUT == 8'h04) else $error("indirect jump on D not four");
   a_mul_zero: assert property (tk && CLASS_IN == CLS_MULTIPLY && MUL_BASE_CLOCKS_IN > 8'h01 &&
      HIGH_RESULT_DESTINATION_IN == 5'h00 && LOW_RESULT_DESTINATION_IN != 5'h00
      |=> LAST_CLOCKS_OUT == $past(MUL_BASE_CLOCKS_IN) - 8'h01) else $error("multiply not shortened");
endmodule // ect_timer_monitor
////////////////////////////////////////////////////////////////////////////////
bind ect_timer ect_timer_monitor u_mon (.CLK_SYS_IN(CLK_SYS_IN), .RSTN_IN(RSTN_IN),
   .ISSUE_VALID_IN(ISSUE_VALID_IN), .COND_TRUE_IN(COND_TRUE_IN), .VARIANT_IN(VARIANT_IN),
   .CLASS_IN(CLASS_IN), .LOW_RESULT_DESTINATION_IN(LOW_RESULT_DESTINATION_IN),
   .HIGH_RESULT_DESTINATION_IN(HIGH_RESULT_DESTINATION_IN), .READ_WAITS_IN(READ_WAITS_IN),
   .FRAME_N_IN(FRAME_N_IN), .MUL_BASE_CLOCKS_IN(MUL_BASE_CLOCKS_IN),
   .LAST_CLOCKS_OUT(LAST_CLOCKS_OUT), .ISSUE_READY_OUT(ISSUE_READY_OUT),
   .ILLEGAL_OP_OUT(ILLEGAL_OP_OUT));

// ==== verification/ect_timer_tb_top.sv ====
// Self-checking testbench for the execution cycle timer
module ect_timer_tb_top
   import ect_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rstn = 0, vld = 0, cd = 0, program_status_word = 0, tk = 0, rdy, ill;
   logic [2:0] var_r = 0;
   logic [4:0] cls = 0, lo = 0, hi = 0;
   logic [3:0] fn = 0, ws = 0, waits;
   logic [7:0] mb = 2, last;
   logic [8:0] en;
   logic [8:0] q[$];
   int n_errors = 0, num_checks = 0;
   initial forever #25 clk = ~clk;
   ect_mem_model u_mem (.ws_in(ws), .waits_out(waits));
   ect_timer u_dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .VARIANT_IN(var_r), .ISSUE_VALID_IN(vld),
      .CLASS_IN(cls), .COND_TRUE_IN(cd), .PSW_WRITE_IN(program_status_word), .READ_WAITS_IN(waits),
      .FRAME_N_IN(fn), .LOW_RESULT_DESTINATION_IN(lo), .HIGH_RESULT_DESTINATION_IN(hi),
      .MUL_BASE_CLOCKS_IN(mb), .ISSUE_READY_OUT(rdy), .ILLEGAL_OP_OUT(ill), .LAST_CLOCKS_OUT(last));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input string s, input logic [8:0] x, g);
      num_checks++;
      if (g !== x) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", s, x, g);
      end
   endtask
   task chk_hold(input logic [7:0] x, input int k);
      chk("hold", {1'b0, x}, 9'(k));
   endtask
   task chk_clocks(input logic [7:0] x, g);
      chk("clocks", {1'b0, x}, {1'b0, g});
   endtask
   task chk_illegal(input logic x, g);
      chk("illegal", {8'h00, x}, {8'h00, g});
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Offer one instruction, note its result, then time how long issue stays held
   task iss(input logic [4:0] c, input logic [2:0] v, input logic d, p, input logic [3:0] n, w,
      input logic [4:0] l, h, input logic [7:0] b, x, input logic il);
      int k;
      @(posedge clk);
      {cls, var_r, cd, program_status_word, fn, ws, lo, hi, mb, vld} <= {c, v, d, p, n, w, l, h, b, 1'b1};
      q.push_back({il, x});
      @(posedge clk);
      vld <= 1'b0;
      #1;
      k = 1;
      while (rdy !== 1'b1 && k < 100) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk_hold(x, k);
   endtask
   always @(posedge clk) begin
      if (tk) begin
         en = q.pop_front();
         chk_clocks(en[7:0], last);
         chk_illegal(en[8], ill);
      end
      tk <= vld && rdy;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int x, l, h, b;
      void'($urandom(48));
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      for (int v = 0; v < 6; v++) begin
         iss(CLS_SINGLE, v, 0, 1, 0, 0, 0, 1, 2, 1, 0);
         iss(CLS_BCOND, v, 1, 0, 0, 0, 0, 1, 2, (v > 2) ? 4 : 3, 0);
         iss(CLS_BCOND, v, 1, 0, 0, 0, 0, 1, 2, 2, 0);
         iss(CLS_BCOND, v, 0, 0, 0, 0, 0, 1, 2, 1, 0);
      end
      $display("test branch done");
      for (int v = 0; v < 6; v++) for (int c = 2; c < 12; c++) if (c != 5) begin
         x = (c == 4) ? 3 : (c == 6) ? 4 : (c < 4) ? 2 : 3;
         x += (v == 3) ? 1 : (v == 4) ? 2 : 0;
         iss(c, v, 0, 0, 0, 0, 0, 1, 2, x, v == 2 && c > 9);
      end
      $display("test control done");
      for (int i = 0; i < 8; i++) begin
         x = (i == 0) ? 15 : $urandom_range(15);
         iss(CLS_BIT_OP, i % 6, 0, 0, 0, x, 0, 1, 2, 3 + x, 0);
      end
      $display("test bit done");
      for (int c = 12; c < 17; c++) for (int n = 0; n < 16; n += 5) begin
         x = ((n == 0) ? 1 : n) + ((c == 13 || c == 16) ? 3 : (c == 15) ? 2 : 1);
         iss(c, 0, 0, 0, n, 0, 0, 1, 2, x, 0);
      end
      $display("test frame done");
      for (int i = 0; i < 12; i++) begin
         l = (i == 0) ? 1 : (i == 1) ? 2 : $urandom_range(3);
         h = (i == 0) ? 0 : (i == 1) ? 2 : $urandom_range(3);
         b = $urandom_range(9, 2);
         x = (l == h) ? b - 1 : b;
         x -= (h == 0 && x > 1) ? 1 : 0;
         iss(CLS_MULTIPLY, 0, 0, 0, 0, 0, l, h, b, x, 0);
      end
      $display("test multiply done");
      close_out;
   end
   initial begin
      #250000;
      n_errors++;
      close_out;
   end
endmodule // ect_timer_tb_top
